// file: hw/ext_irq_defines.vh
// constants for the external pin interrupt unit
`ifndef EXT_IRQ_DEFINES_VH
`define EXT_IRQ_DEFINES_VH
`define SENSE_CTRL_OFF 12'h000
`define IRQ_MASK_OFF 12'h004
`define IRQ_FLAGS_OFF 12'h008
`define POWER_CTRL_OFF 12'h00C
`define PIN_STATUS_OFF 12'h010
`define SENSE_LOW 2'b00
`define SENSE_ANY 2'b01
`define SENSE_FALL 2'b10
`define SENSE_RISE 2'b11
`define SENSE_CTRL_RESET 8'h00
`define IRQ_MASK_RESET 4'h0
`define PWR_SLEEP_BIT 0
`define PWR_MODE_LSB 1
`define PWR_WAKE_BIT 3
`define PWR_WAKE_IRQ_BIT 4
`define MODE_IDLE 2'b00
`define MODE_POWER_DOWN 2'b01
`define MODE_OTHER 2'b10
`define WD_PERIOD_NS 1000
`define CLK_PERIOD_NS 100
`define WD_TICK_CYCLES ((`WD_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_TIME_NS 64000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: hw/pin_sync.v
// two-stage synchroniser for a bus of pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// file: hw/wake_sampler.v
// level wake-up qualifier sampled on a divided watchdog tick
`timescale 1ns/1ps
`include "ext_irq_defines.vh"
module wake_sampler #(
  parameter TICK_CYCLES = `WD_TICK_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire armed,
  input wire level_low,
  // result
  output reg wake_pulse
);
  reg [15:0] tick_cnt_reg;
  reg [1:0] hits_reg;
  wire tick = (tick_cnt_reg == 16'h0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
      hits_reg <= 2'b00;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (!armed) begin
        tick_cnt_reg <= 16'h0000;
        hits_reg <= 2'b00;
      end else begin
        tick_cnt_reg <= tick ? TICK_CYCLES[15:0] - 16'h0001 : tick_cnt_reg - 16'h0001;
        if (tick) begin
          // two consecutive low samples on the watchdog tick before wake
          if (!level_low) begin
            hits_reg <= 2'b00;
          end else if (hits_reg == 2'b01) begin
            hits_reg <= 2'b00;
            wake_pulse <= 1'b1;
          end else begin
            hits_reg <= 2'b01;
          end
        end
      end
    end
  end
endmodule

// file: hw/ext_pin_irq.v
// external pin interrupt unit with apb registers
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ext_irq_defines.vh"
module ext_pin_irq #(
  parameter NUM_PINS = 4,
  parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins and port output path
  input wire [NUM_PINS-1:0] ext_irq_pins,
  input wire [NUM_PINS-1:0] pin_out_value,
  input wire [NUM_PINS-1:0] pin_out_en,
  // core side
  input wire [NUM_PINS-1:0] irq_ack,
  output reg [NUM_PINS-1:0] irq_req,
  output reg wake_up
);
  reg [2*NUM_PINS-1:0] sense_reg;
  reg [NUM_PINS-1:0] mask_reg;
  reg [NUM_PINS-1:0] flags_reg;
  reg [NUM_PINS-1:0] flags_next;
  reg [NUM_PINS-1:0] prev_reg;
  reg sleep_reg;
  reg [1:0] mode_reg;
  reg waking_reg;
  reg wake_irq_reg;
  reg [31:0] su_cnt_reg;
  wire [NUM_PINS-1:0] pin_sync_lvl;
  wire [NUM_PINS-1:0] pin_level;
  wire [NUM_PINS-1:0] evt;
  wire [NUM_PINS-1:0] low_req;
  wire [NUM_PINS-1:0] is_level;
  wire io_clk_run;
  wire pd_armed;
  wire any_low;
  wire wake_pulse;
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & ~pwrite;
  wire addr_ok = (paddr == `SENSE_CTRL_OFF) | (paddr == `IRQ_MASK_OFF) | (paddr == `IRQ_FLAGS_OFF) |
                 (paddr == `POWER_CTRL_OFF) | (paddr == `PIN_STATUS_OFF);

  pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_irq_pins),
    .sync_out(pin_sync_lvl)
  );

  // a pin driven as output reflects the driven value, so software can trigger it
  assign pin_level = (pin_out_en & pin_out_value) | (~pin_out_en & pin_sync_lvl);

  // io clock is gated off in every sleep mode but idle
  assign io_clk_run = ~sleep_reg | (mode_reg == `MODE_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      wire [1:0] sel = sense_reg[2*gi+1:2*gi];
      wire rise = pin_level[gi] & ~prev_reg[gi];
      wire fall = ~pin_level[gi] & prev_reg[gi];
      assign evt[gi] = io_clk_run & (
        ((sel == `SENSE_ANY) & (rise | fall)) |
        ((sel == `SENSE_FALL) & fall) |
        ((sel == `SENSE_RISE) & rise));
      assign is_level[gi] = (sel == `SENSE_LOW);
      assign low_req[gi] = is_level[gi] & ~pin_level[gi];
    end
  endgenerate

  assign any_low = |(low_req & mask_reg);
  assign pd_armed = sleep_reg & (mode_reg == `MODE_POWER_DOWN) & ~waking_reg;

  wake_sampler #(
    .TICK_CYCLES(`WD_TICK_CYCLES)
  ) u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .armed(pd_armed),
    .level_low(any_low),
    .wake_pulse(wake_pulse)
  );

  always @* begin
    flags_next = flags_reg;
    if (wr_acc && paddr == `IRQ_FLAGS_OFF) begin
      flags_next = flags_next & ~pwdata[NUM_PINS-1:0];
    end
    flags_next = flags_next & ~irq_ack;
    flags_next = flags_next | evt;
    flags_next = flags_next & ~is_level;
  end

  // sense, mask, flags and pin history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= {(2*NUM_PINS){1'b0}};
      mask_reg <= {NUM_PINS{1'b0}};
      flags_reg <= {NUM_PINS{1'b0}};
      prev_reg <= {NUM_PINS{1'b0}};
      irq_req <= {NUM_PINS{1'b0}};
    end else begin
      // history only advances while the io clock runs, so a level change during a stop is seen as an edge once it runs again
      if (io_clk_run) begin
        prev_reg <= pin_level;
      end
      if (wr_acc && paddr == `SENSE_CTRL_OFF) begin
        sense_reg <= pwdata[2*NUM_PINS-1:0];
      end
      if (wr_acc && paddr == `IRQ_MASK_OFF) begin
        mask_reg <= pwdata[NUM_PINS-1:0];
      end
      flags_reg <= flags_next;
      // level requests wait through power-down sampling and start-up, so a vanished level gives no irq
      irq_req <= mask_reg & (flags_next | (low_req & {NUM_PINS{~(waking_reg | pd_armed)}}));
    end
  end

  // sleep control and power-down wake-up sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      mode_reg <= `MODE_IDLE;
      waking_reg <= 1'b0;
      wake_irq_reg <= 1'b0;
      su_cnt_reg <= 32'h00000000;
      wake_up <= 1'b0;
    end else begin
      wake_up <= 1'b0;
      if (wr_acc && paddr == `POWER_CTRL_OFF) begin
        sleep_reg <= pwdata[`PWR_SLEEP_BIT];
        mode_reg <= pwdata[`PWR_MODE_LSB+1:`PWR_MODE_LSB];
      end
      if (sleep_reg && mode_reg == `MODE_IDLE && (|evt || any_low)) begin
        sleep_reg <= 1'b0;
        wake_up <= 1'b1;
      end
      if (wake_pulse) begin
        waking_reg <= 1'b1;
        su_cnt_reg <= STARTUP_CYCLES[31:0] - 32'h00000001;
        wake_irq_reg <= 1'b0;
      end else if (waking_reg) begin
        if (su_cnt_reg == 32'h00000000) begin
          // wake regardless; irq only if level still held at the end
          waking_reg <= 1'b0;
          sleep_reg <= 1'b0;
          wake_up <= 1'b1;
          wake_irq_reg <= any_low;
        end else begin
          su_cnt_reg <= su_cnt_reg - 32'h00000001;
        end
      end
    end
  end

  // apb slave: zero wait states, error on unmapped offsets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= 32'h00000000;
      if (rd_acc && !penable) begin
        case (paddr)
          `SENSE_CTRL_OFF: prdata <= {{(32-2*NUM_PINS){1'b0}}, sense_reg};
          `IRQ_MASK_OFF: prdata <= {{(32-NUM_PINS){1'b0}}, mask_reg};
          `IRQ_FLAGS_OFF: prdata <= {{(32-NUM_PINS){1'b0}}, flags_reg};
          `POWER_CTRL_OFF: prdata <= {27'h0000000, wake_irq_reg, waking_reg, mode_reg, sleep_reg};
          `PIN_STATUS_OFF: prdata <= {{(32-NUM_PINS){1'b0}}, pin_level};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: tb/irq_checker.sv
// port-level assertions for the external pin interrupt unit
`timescale 1ns/1ps
`include "ext_irq_defines.vh"
module irq_checker #(parameter NUM_PINS = 4, parameter STARTUP_CYCLES = 8) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins and core side
  input wire [NUM_PINS-1:0] ext_irq_pins,
  input wire [NUM_PINS-1:0] pin_out_value,
  input wire [NUM_PINS-1:0] pin_out_en,
  input wire [NUM_PINS-1:0] irq_ack,
  input wire [NUM_PINS-1:0] irq_req,
  input wire wake_up
);
  // an output-enabled pin is seen at its driven value
  wire [NUM_PINS-1:0] eff = (pin_out_en & pin_out_value) | (~pin_out_en & ext_irq_pins);
  wire wr = psel && penable && pready && pwrite;
  reg [NUM_PINS-1:0] mask_reg;
  reg [1:0] sense_reg;
  reg sleep_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
      sense_reg <= 2'h0;
      sleep_reg <= 1'b0;
    end else begin
      if (wr && paddr == `IRQ_MASK_OFF) mask_reg <= pwdata[NUM_PINS-1:0];
      if (wr && paddr == `SENSE_CTRL_OFF) sense_reg <= pwdata[1:0];
      if (wake_up) sleep_reg <= 1'b0;
      else if (wr && paddr == `POWER_CTRL_OFF) sleep_reg <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  // requests may lag a mask clear by the one registered cycle
  a_req_masked: assert property ((irq_req & ~mask_reg & ~$past(mask_reg)) == '0) else $error("masked req");
  a_level_track: assert property (($stable(eff[0]) && $stable(sense_reg) && $stable(mask_reg) && !sleep_reg) [*4]
    ##0 sense_reg == `SENSE_LOW |-> irq_req[0] == (mask_reg[0] && !eff[0])) else $error("level req");
  a_edge_seen: assert property (sense_reg != `SENSE_LOW && mask_reg[0] && !sleep_reg && !irq_ack[0] &&
    (sense_reg == `SENSE_RISE ? $rose(eff[0]) : sense_reg == `SENSE_FALL ? $fell(eff[0]) : $changed(eff[0]))
    |-> ##[1:3] irq_req[0]) else $error("edge missed");
  a_ack_clear: assert property (($stable(eff[0]) && $stable(sense_reg)) [*4]
    ##0 (irq_ack[0] && sense_reg != `SENSE_LOW) |=> !irq_req[0]) else $error("ack ignored");
  a_wake_pulse: assert property (wake_up |=> !wake_up) else $error("long wake");
  a_wake_asleep: assert property (wake_up |-> sleep_reg) else $error("wake awake");
  c_wake: cover property (wake_up);
  c_refused: cover property (pready && pslverr);
  c_ack: cover property (irq_ack[0] && irq_req[0]);
endmodule
bind ext_pin_irq irq_checker #(.NUM_PINS(NUM_PINS), .STARTUP_CYCLES(STARTUP_CYCLES)) chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .ext_irq_pins(ext_irq_pins),
  .pin_out_value(pin_out_value),
  .pin_out_en(pin_out_en),
  .irq_ack(irq_ack),
  .irq_req(irq_req),
  .wake_up(wake_up)
);

// file: tb/pin_source.sv
// behavioural model of the outside circuit driving the interrupt pins
`timescale 1ns/1ps
module pin_source (
  // clock
  input wire pclk,
  // pins, idle high
  output logic [3:0] pins
);
  initial pins = 4'hF;
  // low for w cycles; a long w keeps the level through the whole wake-up
  task pulse_low(input int n, input int w);
    pins[n] <= 1'b0;
    repeat (w) @(posedge pclk);
    pins[n] <= 1'b1;
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`include "ext_irq_defines.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_up, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ext_irq_pins, pin_out_value, pin_out_en, irq_ack, irq_req;
  int bad_count, checks, i, m;
  ext_pin_irq #(.STARTUP_CYCLES(40)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_irq_pins(ext_irq_pins),
    .pin_out_value(pin_out_value),
    .pin_out_en(pin_out_en),
    .irq_ack(irq_ack),
    .irq_req(irq_req),
    .wake_up(wake_up)
  );
  pin_source src (.pclk(pclk), .pins(ext_irq_pins));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // pready and read data are taken as they stood at the rising edge, before that edge's updates land
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle(input logic [3:0] exp);
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk({28'h0, irq_req}, {28'h0, exp});
    @(posedge pclk);
  endtask
  task t_edges;
    for (m = 1; m < 4; m++) begin
      apb(1'b1, `SENSE_CTRL_OFF, m);
      src.pulse_low(0, 2);
      settle(4'h1);
      apb(1'b0, `IRQ_FLAGS_OFF, 32'h0);
      chk(rd, 32'h1);
      if (m == 3) begin
        irq_ack <= 4'h1;
        @(posedge pclk);
        irq_ack <= 4'h0;
      end else apb(1'b1, `IRQ_FLAGS_OFF, 32'h1);
      settle(4'h0);
    end
  endtask
  // a masked pin still sets its flag but raises no request
  task t_mask;
    apb(1'b1, `IRQ_MASK_OFF, 32'hE);
    apb(1'b1, `SENSE_CTRL_OFF, `SENSE_FALL);
    src.pulse_low(0, 2);
    settle(4'h0);
    apb(1'b0, `IRQ_FLAGS_OFF, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `PIN_STATUS_OFF, 32'h0);
    chk(rd, 32'hF);
    apb(1'b1, `IRQ_FLAGS_OFF, 32'h1);
    apb(1'b1, `IRQ_MASK_OFF, 32'hF);
  endtask
  task t_level;
    apb(1'b1, `SENSE_CTRL_OFF, `SENSE_LOW);
    pin_out_value <= 4'h0;
    pin_out_en <= 4'h1;
    settle(4'h1);
    apb(1'b0, `IRQ_FLAGS_OFF, 32'h0);
    chk(rd, 32'h0);
    pin_out_value <= 4'h1;
    settle(4'h0);
    pin_out_en <= 4'h0;
  endtask
  // only idle keeps the edge detector clocked
  task t_sleep_edges;
    apb(1'b1, `SENSE_CTRL_OFF, `SENSE_RISE);
    for (m = 0; m < 3; m++) begin
      apb(1'b1, `POWER_CTRL_OFF, {m[1:0], 1'b1});
      src.pulse_low(0, 2);
      repeat (6) @(posedge pclk);
      apb(1'b1, `POWER_CTRL_OFF, 32'h0);
      apb(1'b0, `IRQ_FLAGS_OFF, 32'h0);
      chk(rd, m == 0);
      apb(1'b1, `IRQ_FLAGS_OFF, 32'h1);
    end
  endtask
  task t_wake(input int w, input logic [31:0] exp);
    apb(1'b1, `SENSE_CTRL_OFF, `SENSE_LOW);
    apb(1'b1, `POWER_CTRL_OFF, 32'h3);
    fork
      src.pulse_low(0, w);
      begin
        repeat (15) @(negedge pclk);
        chk(irq_req[0], 1'b0);
        for (i = 0; i < 300 && wake_up !== 1'b1; i++) @(negedge pclk);
        chk(wake_up, 1'b1);
        if (i == 300) finish_test();
        @(negedge pclk);
        chk(irq_req[0], exp[4]);
      end
    join
    apb(1'b0, `POWER_CTRL_OFF, 32'h0);
    chk(rd & 32'h11, exp);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_out_value, pin_out_en, irq_ack} = '0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SENSE_CTRL_OFF, 32'h0);
    chk(rd, `SENSE_CTRL_RESET);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, `IRQ_MASK_OFF, 32'hF);
    apb(1'b0, `IRQ_MASK_OFF, 32'h0);
    chk(rd, 32'hF);
    t_edges();
    t_mask();
    t_level();
    t_sleep_edges();
    t_wake(100, 32'h10);
    t_wake(26, 32'h0);
    finish_test();
  end
endmodule
